// ---- rad_rs485_ctrl.sv ----
// RS-485 auto direction and multidrop receive support
`timescale 1ns/100ps
`include "rad_defs.svh"
module rad_rs485_ctrl
    import rad_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic [7:0] modem_control_reg,
    input  wire logic [7:0] extra_feature_control,
    input  wire logic [7:0] enhanced_feature_reg,
    input  wire logic [7:0] line_control_reg,
    input  wire logic [7:0] interrupt_enable_reg,
    input  wire logic [7:0] flow_stop_char_two,
    input  wire logic       hw_flow_en,
    input  wire logic       hw_flow_rts,
    input  wire logic       tx_pending,
    input  wire logic       tx_shift_busy,
    input  wire logic       rx_en_set,
    input  wire logic       rx_en_clr,
    input  wire logic       rx_valid,
    input  wire logic [7:0] rx_data,
    input  wire logic       rx_ninth,
    output logic            rts_n,
    output logic            rx_en,
    output logic            fifo_push,
    output logic [7:0]      fifo_data,
    output logic            fifo_perr,
    output logic            line_irq
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    // Registered copies of every output, so no pin ever glitches
    logic       rts_n_r;      // Direction pin level
    logic       rx_en_r;      // Receiver enable flag
    logic       fifo_push_r;  // One-cycle write strobe
    logic [7:0] fifo_data_r;  // Character beside the strobe
    logic       fifo_perr_r;  // Ninth bit in the error slot
    logic       line_irq_r;   // One-cycle line status request
    rad_class_e rx_class;     // Verdict on the character in flight

    // ------------------------------------------------------------
    // Control decode
    // ------------------------------------------------------------
    // Feature enables picked out of the register images
    wire logic auto_dir = extra_feature_control[`RAD_EFC_AUTODIR_BIT];
    wire logic invert   = extra_feature_control[`RAD_EFC_INVERT_BIT];
    wire logic md_en    = extra_feature_control[`RAD_EFC_MULTIDROP_BIT];
    wire logic spec_en  = enhanced_feature_reg[`RAD_ENH_SPECIAL_BIT];
    wire logic line_ie  = interrupt_enable_reg[`RAD_IEN_LINE_BIT];
    wire logic mdm_rts  = modem_control_reg[`RAD_MODEM_RTS_BIT];
    // Parity setting is passed on for visibility only; an address is
    // flagged even if software forgot to force parity
    wire logic force_p0 = line_control_reg[`RAD_LINE_PARITY_HI:`RAD_LINE_PARITY_LO] == `RAD_LINE_FORCE_P0;

    // ------------------------------------------------------------
    // Direction control
    // ------------------------------------------------------------
    // Direction stays active until the last stop bit leaves the shifter;
    // watching the FIFO alone would cut the final character short
    wire logic tx_active = tx_pending | tx_shift_busy;
    // Normal polarity pulls the pin low while sending, inverted drives it high
    wire logic auto_rts  = invert ? tx_active : ~tx_active;
    // A set modem bit is a request, which is a low pin
    wire logic mdm_pin   = ~mdm_rts;
    wire logic man_rts   = hw_flow_en ? hw_flow_rts : mdm_pin;
    // Auto mode wins even if flow control was left on
    wire logic rts_nxt   = auto_dir ? auto_rts : man_rts;

    // ------------------------------------------------------------
    // Character filter
    // ------------------------------------------------------------
    // The filter stays purely combinational; all timing lives here
    rad_rx_if rxi();
    assign rxi.valid = rx_valid;
    assign rxi.data  = rx_data;
    assign rxi.ninth = rx_ninth;
    assign rxi.rx_en = rx_en_r;

    rad_md_filter u_filt
    (
        .rx         (rxi.filt),
        .md_en      (md_en),
        .special_en (spec_en),
        .force_p0   (force_p0),
        .match_char (flow_stop_char_two)
    );

    // One verdict per character, so strobe and flag cannot disagree
    assign rx_class = !rx_valid ? RAD_CH_NONE  :
                      !rxi.keep ? RAD_CH_DROP  :
                      rxi.perr  ? RAD_CH_ADDR  :
                                  RAD_CH_STORE;

    // Store and address verdicts both write the receive FIFO
    wire logic push_nxt = (rx_class == RAD_CH_STORE) | (rx_class == RAD_CH_ADDR);
    // Ninth bit reported in the parity error slot
    wire logic perr_nxt = rx_class == RAD_CH_ADDR;
    // Line interrupt only for a stored address and only when allowed
    wire logic irq_nxt  = perr_nxt & line_ie;

    // ------------------------------------------------------------
    // Receiver enable flag
    // ------------------------------------------------------------
    // Controller clear closes the receiver at the end of a message
    wire logic ctl_keep = rx_en_r & ~rx_en_clr;
    // A foreign address closes it in auto detection mode
    wire logic hw_keep  = ctl_keep & ~rxi.clr_en;
    // Any set beats any clear in the same cycle, so a matching address
    // is never lost to a controller write landing in the same clock
    wire logic en_nxt   = rxi.set_en | hw_keep | rx_en_set;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    // Direction pin; a glitch here would key the line driver for
    // a moment and corrupt another station's frame
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rts_n_r <= `RAD_RTS_RESET;
        end
        else
        begin
            rts_n_r <= rts_nxt;
        end
    end

    // Receiver enable flag, written by controller and address detection
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            rx_en_r <= `RAD_RX_EN_RESET;
        end
        else
        begin
            rx_en_r <= en_nxt;
        end
    end

    // Write strobe lasts exactly one cycle per kept character
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fifo_push_r <= `RAD_PUSH_RESET;
        end
        else
        begin
            fifo_push_r <= push_nxt;
        end
    end

    // Data follows the input every cycle; only the strobe makes it count,
    // which saves a load enable on eight flops
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fifo_data_r <= `RAD_DATA_RESET;
        end
        else
        begin
            fifo_data_r <= rx_data;
        end
    end

    // Error slot carries the ninth bit of a stored address
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fifo_perr_r <= `RAD_PERR_RESET;
        end
        else
        begin
            fifo_perr_r <= perr_nxt;
        end
    end

    // Interrupt request pulses alongside the flagged write
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            line_irq_r <= `RAD_IRQ_RESET;
        end
        else
        begin
            line_irq_r <= irq_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Ports are plain wires onto the flops above
    assign rts_n     = rts_n_r;
    assign rx_en     = rx_en_r;
    assign fifo_push = fifo_push_r;
    assign fifo_data = fifo_data_r;
    assign fifo_perr = fifo_perr_r;
    assign line_irq  = line_irq_r;
endmodule

// ---- rad_defs.svh ----
// Constant definitions for the RS-485 direction and multidrop block
`ifndef RAD_DEFS_SVH
`define RAD_DEFS_SVH

// ------------------------------------------------------------
// Control bit positions
// ------------------------------------------------------------
`define RAD_EFC_MULTIDROP_BIT 0
`define RAD_EFC_AUTODIR_BIT   4
`define RAD_EFC_INVERT_BIT    5
`define RAD_MODEM_RTS_BIT     1
`define RAD_ENH_SPECIAL_BIT   5
`define RAD_IEN_LINE_BIT      2
`define RAD_LINE_PARITY_HI    5
`define RAD_LINE_PARITY_LO    3
`define RAD_LINE_FORCE_P0     3'h7

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define RAD_RTS_RESET         1'b1
`define RAD_RX_EN_RESET       1'b0
`define RAD_PUSH_RESET        1'b0
`define RAD_DATA_RESET        8'h00
`define RAD_PERR_RESET        1'b0
`define RAD_IRQ_RESET         1'b0

`endif

// ---- rad_pkg.sv ----
// Types shared by the RS-485 direction and multidrop block
package rad_pkg;
    // Classification of one received character
    typedef enum logic [3:0]
    {
        RAD_CH_DROP  = 4'h1,
        RAD_CH_STORE = 4'h2,
        RAD_CH_ADDR  = 4'h4,
        RAD_CH_NONE  = 4'h8
    } rad_class_e;
endpackage

// ---- rad_rx_if.sv ----
// Interface carrying a received character to the multidrop filter
`timescale 1ns/100ps
interface rad_rx_if;
    logic       valid;
    logic [7:0] data;
    logic       ninth;
    logic       rx_en;
    logic       keep;
    logic       perr;
    logic       set_en;
    logic       clr_en;

    modport top
    (
        output valid,
        output data,
        output ninth,
        output rx_en,
        input  keep,
        input  perr,
        input  set_en,
        input  clr_en
    );
    modport filt
    (
        input  valid,
        input  data,
        input  ninth,
        input  rx_en,
        output keep,
        output perr,
        output set_en,
        output clr_en
    );
endinterface

// ---- rad_md_filter.sv ----
// Combinational multidrop character filter
`timescale 1ns/100ps
`include "rad_defs.svh"
module rad_md_filter
    import rad_pkg::*;
(
    rad_rx_if.filt     rx,
    input  wire logic  md_en,
    input  wire logic  special_en,
    input  wire logic  force_p0,
    input  wire logic [7:0] match_char
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    wire logic is_addr  = md_en & rx.ninth;
    wire logic is_match = rx.data == match_char;
    wire logic auto_det = md_en & special_en;
    wire logic norm_md  = md_en & ~special_en;

    // Normal mode: data dropped while disabled, address always stored
    wire logic keep_norm = is_addr | rx.rx_en;
    // Auto mode: only matching address or data while enabled survive
    wire logic keep_auto = is_addr ? is_match : rx.rx_en;

    assign rx.keep   = rx.valid & (~md_en | (norm_md ? keep_norm : keep_auto));
    // Both modes carry the ninth bit; the forced parity setting has no effect on it
    assign rx.perr   = rx.valid & is_addr & (auto_det ? 1'b1 : force_p0 | 1'b1);
    assign rx.set_en = rx.valid & auto_det & is_addr & is_match;
    assign rx.clr_en = rx.valid & auto_det & is_addr & ~is_match;
endmodule

// ---- rad_rs485_ctrl_checker.sv ----
// Checker for the RS-485 direction and multidrop block
`timescale 1ns/100ps
`include "rad_defs.svh"
module rad_rs485_ctrl_checker
(
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic [7:0] modem_control_reg,
    input wire logic [7:0] extra_feature_control,
    input wire logic [7:0] enhanced_feature_reg,
    input wire logic [7:0] line_control_reg,
    input wire logic [7:0] interrupt_enable_reg,
    input wire logic [7:0] flow_stop_char_two,
    input wire logic       hw_flow_en,
    input wire logic       hw_flow_rts,
    input wire logic       tx_pending,
    input wire logic       tx_shift_busy,
    input wire logic       rx_en_set,
    input wire logic       rx_en_clr,
    input wire logic       rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic       rx_ninth,
    input wire logic       rts_n,
    input wire logic       rx_en,
    input wire logic       fifo_push,
    input wire logic [7:0] fifo_data,
    input wire logic       fifo_perr,
    input wire logic       line_irq
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // Shorthands; md folds valid in so each antecedent stays one line
    wire logic busy = tx_pending | tx_shift_busy;
    wire logic auto = extra_feature_control[`RAD_EFC_AUTODIR_BIT];
    wire logic inv  = extra_feature_control[`RAD_EFC_INVERT_BIT];
    wire logic md   = extra_feature_control[`RAD_EFC_MULTIDROP_BIT] & rx_valid;
    wire logic sp   = enhanced_feature_reg[`RAD_ENH_SPECIAL_BIT];
    wire logic mreq = modem_control_reg[`RAD_MODEM_RTS_BIT];
    wire logic lie  = interrupt_enable_reg[`RAD_IEN_LINE_BIT];
    sequence s_addr; md && rx_ninth; endsequence
    sequence s_match; s_addr ##0 sp && rx_data == flow_stop_char_two; endsequence
    property p_modem; !auto && !hw_flow_en |=> rts_n != $past(mreq); endproperty
    a_modem: assert property (p_modem) else $error("rts_n not from modem bit");
    property p_auto; auto && !inv && busy |=> !rts_n; endproperty
    a_auto: assert property (p_auto) else $error("rts_n high while sending");
    property p_inv; auto && inv && busy |=> rts_n; endproperty
    a_inv: assert property (p_inv) else $error("inverted rts_n low while sending");
    property p_idle; auto && !busy |=> rts_n != $past(inv); endproperty
    a_idle: assert property (p_idle) else $error("idle rts_n wrong level");
    property p_drop; md && !rx_ninth && !rx_en |=> !fifo_push; endproperty
    a_drop: assert property (p_drop) else $error("data kept while disabled");
    property p_addr; s_addr ##0 !sp |=> fifo_push && fifo_perr && fifo_data == $past(rx_data); endproperty
    a_addr: assert property (p_addr) else $error("address not stored flagged");
    property p_match; s_match |=> fifo_push && fifo_perr && rx_en; endproperty
    a_match: assert property (p_match) else $error("matching address mishandled");
    property p_miss;
        s_addr ##0 sp && rx_data != flow_stop_char_two && !rx_en_set |=> !fifo_push && !rx_en;
    endproperty
    a_miss: assert property (p_miss) else $error("foreign address mishandled");
    property p_irq; line_irq == (fifo_push && fifo_perr && $past(lie)); endproperty
    a_irq: assert property (p_irq) else $error("line interrupt wrong");
    property p_off; rx_valid && !extra_feature_control[`RAD_EFC_MULTIDROP_BIT] |=> fifo_push && !fifo_perr; endproperty
    a_off: assert property (p_off) else $error("plain mode char not stored");
endmodule
bind rad_rs485_ctrl rad_rs485_ctrl_checker chk_u (.*);

// ---- rad_station.sv ----
// Master station model feeding characters to the receiver
`timescale 1ns/100ps
module rad_station (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [8:0] ch,
    output logic            rx_valid,
    output logic [7:0]      rx_data,
    output logic            rx_ninth
);
    // Between characters the lines flip so stale data never looks valid
    always_ff @(posedge clk)
    begin
        rx_valid <= go;
        {rx_ninth, rx_data} <= go ? ch : ~{rx_ninth, rx_data};
    end
endmodule

// ---- rad_rs485_ctrl_bench.sv ----
// Self-checking bench for the RS-485 direction and multidrop block
`timescale 1ns/100ps
module rad_rs485_ctrl_bench;
    logic clk, resetn, hw_flow_en, hw_flow_rts, tx_pending, tx_shift_busy, rx_en_set, rx_en_clr, go, en;
    logic rx_valid, rx_ninth, rts_n, rx_en, fifo_push, fifo_perr, line_irq;
    logic [7:0] modem_control_reg, extra_feature_control, enhanced_feature_reg, line_control_reg;
    logic [7:0] interrupt_enable_reg, flow_stop_char_two, rx_data, fifo_data;
    logic [8:0] ch;
    logic [9:0] q[$];
    int errors = 0, n_compared = 0, cyc = 0, seed = 63;
    rad_rs485_ctrl dut_u
    (
        .clk                   (clk),
        .resetn                (resetn),
        .modem_control_reg     (modem_control_reg),
        .extra_feature_control (extra_feature_control),
        .enhanced_feature_reg  (enhanced_feature_reg),
        .line_control_reg      (line_control_reg),
        .interrupt_enable_reg  (interrupt_enable_reg),
        .flow_stop_char_two    (flow_stop_char_two),
        .hw_flow_en            (hw_flow_en),
        .hw_flow_rts           (hw_flow_rts),
        .tx_pending            (tx_pending),
        .tx_shift_busy         (tx_shift_busy),
        .rx_en_set             (rx_en_set),
        .rx_en_clr             (rx_en_clr),
        .rx_valid              (rx_valid),
        .rx_data               (rx_data),
        .rx_ninth              (rx_ninth),
        .rts_n                 (rts_n),
        .rx_en                 (rx_en),
        .fifo_push             (fifo_push),
        .fifo_data             (fifo_data),
        .fifo_perr             (fifo_perr),
        .line_irq              (line_irq)
    );
    rad_station st_u (.clk, .go, .ch, .rx_valid, .rx_data, .rx_ninth);
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task chk(string nm, logic [9:0] s, logic [9:0] e);
        n_compared++;
        if (s !== e)
        begin
            errors++;
            $display("ERROR %s exp %h seen %h", nm, e, s);
        end
    endtask
    task test_done;
        if (errors == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task rts(logic [7:0] ef, logic fl, logic [1:0] tx, logic e);
        @(posedge clk);
        {extra_feature_control, hw_flow_en, tx_pending, tx_shift_busy} <= {ef, fl, tx};
        @(posedge clk);
        @(negedge clk);
        chk("rts_n", rts_n, e);
    endtask
    task mode(logic [7:0] ef, logic [7:0] enh, logic [7:0] ien);
        @(posedge clk);
        {extra_feature_control, enhanced_feature_reg, interrupt_enable_reg} <= {ef, enh, ien};
    endtask
    task ctl(logic s, logic c);
        @(posedge clk);
        {rx_en_set, rx_en_clr} <= {s, c};
        en = s | (en & ~c);
        @(posedge clk);
        {rx_en_set, rx_en_clr} <= 2'b00;
    endtask
    // Expected push is noted before the character leaves the station
    task send(logic a, logic [7:0] d);
        logic hit;
        logic m;
        @(posedge clk);
        m = extra_feature_control[0];
        if (!a) d = 8'($random(seed));
        hit = !enhanced_feature_reg[5] || d == flow_stop_char_two;
        if (m && a) en = hit & (en | enhanced_feature_reg[5]);
        if (!m || (a && hit) || (!a && en)) q.push_back({d, m & a, m & a & interrupt_enable_reg[2]});
        go <= 1'b1;
        ch <= {a, d};
        @(posedge clk);
        go <= 1'b0;
        @(posedge clk);
        @(negedge clk);
        chk("rx_en", rx_en, en);
    endtask
    // ----------------------------------------
    // Clock, monitor and main sequence
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Pops the oldest note per push; an unexpected push is forced to mismatch.
    // Looks on the falling edge, when the registered outputs have settled
    always @(negedge clk)
    begin
        cyc++;
        if (fifo_push === 1'b1) chk("fifo", {fifo_data, fifo_perr, line_irq}, q.size() ? q.pop_front() : ~{fifo_data, fifo_perr, line_irq});
        if (cyc == 3000)
        begin
            errors++;
            test_done;
        end
    end
    initial
    begin
        {go, ch, hw_flow_en, tx_pending, tx_shift_busy, rx_en_set, rx_en_clr, en, resetn} = '0;
        {modem_control_reg, hw_flow_rts, extra_feature_control, enhanced_feature_reg} = {8'h02, 17'h1_0000};
        {line_control_reg, interrupt_enable_reg, flow_stop_char_two} = {8'h38, 8'h00, 8'h5a};
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        rts(8'h00, 1'b0, 2'b11, 1'b0);
        rts(8'h00, 1'b1, 2'b00, 1'b1);
        rts(8'h10, 1'b0, 2'b10, 1'b0);
        rts(8'h10, 1'b1, 2'b10, 1'b0);
        rts(8'h10, 1'b0, 2'b01, 1'b0);
        rts(8'h10, 1'b0, 2'b00, 1'b1);
        rts(8'h30, 1'b0, 2'b01, 1'b1);
        rts(8'h30, 1'b0, 2'b00, 1'b0);
        mode(8'h00, 8'h00, 8'h04);
        send(1'b1, 8'h33);
        send(1'b0, 8'h00);
        mode(8'h01, 8'h00, 8'h04);
        send(1'b0, 8'h00);
        send(1'b1, 8'h77);
        ctl(1'b1, 1'b0);
        send(1'b0, 8'h00);
        send(1'b1, 8'h12);
        ctl(1'b0, 1'b1);
        send(1'b0, 8'h00);
        mode(8'h01, 8'h20, 8'h00);
        send(1'b1, 8'h11);
        send(1'b1, 8'h5a);
        send(1'b0, 8'h00);
        send(1'b1, 8'h11);
        send(1'b0, 8'h00);
        repeat (3) @(posedge clk);
        chk("left", 10'(q.size()), 10'h000);
        test_done;
    end
endmodule
